// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
	// ----------------------------------------
	// Stimulus and design
	// ----------------------------------------
	logic sys_clk = 0, rst = 1, wrStb = 0, rdStb = 0;
	logic [5:0] addr = 0;
	logic [7:0] wrData = 0, rdData;
	logic [7:0] strengthI = 0, strengthQ = 0, halfWeak = 0, halfStrong = 0;
	logic halfValid = 0, commActive = 0, rxActive = 0;
	logic rxBitValid = 0, rxBit = 0, rxBitIsParity = 0, rxParityExp = 0;
	logic chanQ, evalEn, collision, pllFreeze, parityGenEn, parityChkEn;
	logic dataValid, dataBit, parityErr;
	logic [1:0] pllTc;
	logic [3:0] respBits;
	int mismatches = 0, checks_done = 0;
	logic [7:0] d;

	rxdf_config rxdf_config_i (.sys_clk(sys_clk), .rst(rst), .addr(addr),
		.wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
		.strengthI(strengthI), .strengthQ(strengthQ), .halfValid(halfValid),
		.halfWeak(halfWeak), .halfStrong(halfStrong), .commActive(commActive),
		.rxActive(rxActive), .rxBitValid(rxBitValid), .rxBit(rxBit),
		.rxBitIsParity(rxBitIsParity), .rxParityExp(rxParityExp),
		.chanQ(chanQ), .evalEn(evalEn), .collision(collision), .pllTc(pllTc),
		.pllFreeze(pllFreeze), .respBits(respBits),
		.parityGenEn(parityGenEn), .parityChkEn(parityChkEn),
		.dataValid(dataValid), .dataBit(dataBit), .parityErr(parityErr));

	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		addr <= a;
		wrData <= v;
		wrStb <= 1;
		@(posedge sys_clk);
		wrStb <= 0;
	endtask

	task rd(input logic [5:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		addr <= a;
		rdStb <= 1;
		@(posedge sys_clk);
		rdStb <= 0;
		#1 v = rdData;
	endtask

	// Two edges: one for register update, one for the registered outputs
	task settle;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	task setS(input logic [7:0] i, input logic [7:0] q);
		@(posedge sys_clk);
		strengthI <= i;
		strengthQ <= q;
		settle;
	endtask

	task sendBit(input logic b, input logic p, input logic e);
		@(posedge sys_clk);
		rxBitValid <= 1;
		rxBit <= b;
		rxBitIsParity <= p;
		rxParityExp <= e;
		@(posedge sys_clk);
		rxBitValid <= 0;
		#1;
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		logic [7:0] rv [7];
		logic [7:0] wv [7];
		rv = '{8'h84, 8'h4d, 8'h00, 8'h00, 8'h62, 8'h00, 8'h00};
		// Writing all ones exposes every reserved bit that resets to zero
		wv = '{8'hf7, 8'hef, 8'h00, 8'h00, 8'h63, 8'h10, 8'h00};
		settle;
		chk(respBits, 8'h09);
		chk(parityChkEn, 1);
		for (int k = 0; k < 7; k++) begin
			rd(6'(6'h18 + k), d);
			chk(d, rv[k]);
		end
		@(posedge sys_clk);
		#1 chk(rdData, 8'h00);
		for (int k = 0; k < 7; k++) begin
			wr(6'(6'h18 + k), 8'hff);
			rd(6'(6'h18 + k), d);
			chk(d, wv[k]);
		end
		wr(6'h3f, 8'hff);
		rd(6'h3f, d);
		chk(d, 8'h00);
		$display("test regs done");
	endtask

	task t_resp;
		for (int v = 0; v < 4; v++) begin
			wr(6'h1c, v[7:0]);
			settle;
			chk(respBits, v[7:0] + 8'h07);
		end
		$display("test response time done");
	endtask

	task t_chan;
		wr(6'h18, 8'h00);
		wr(6'h19, 8'h20);
		setS(8'h10, 8'h90);
		chk(chanQ, 0);
		wr(6'h19, 8'h60);
		settle;
		chk(chanQ, 1);
		wr(6'h19, 8'h00);
		setS(8'h90, 8'h10);
		chk(chanQ, 0);
		wr(6'h19, 8'h40);
		setS(8'h10, 8'h90);
		chk(chanQ, 1);
		@(posedge sys_clk);
		commActive <= 1;
		setS(8'h90, 8'h10);
		chk(chanQ, 1);
		@(posedge sys_clk);
		commActive <= 0;
		settle;
		chk(chanQ, 0);
		$display("test channel done");
	endtask

	task t_level;
		wr(6'h19, 8'h20);
		wr(6'h18, 8'h84);
		setS(8'h7f, 8'hff);
		chk(evalEn, 0);
		setS(8'h80, 8'h00);
		chk(evalEn, 1);
		@(posedge sys_clk);
		halfValid <= 1;
		halfStrong <= 8'h80;
		halfWeak <= 8'h40;
		settle;
		chk(collision, 1);
		@(posedge sys_clk);
		halfWeak <= 8'h3f;
		settle;
		chk(collision, 0);
		$display("test levels done");
	endtask

	task t_pll;
		wr(6'h19, 8'h0e);
		@(posedge sys_clk);
		rxActive <= 1;
		settle;
		chk({pllFreeze, pllTc}, 8'h03);
		@(posedge sys_clk);
		rxActive <= 0;
		settle;
		chk({pllFreeze, pllTc}, 8'h02);
		wr(6'h19, 8'h01);
		@(posedge sys_clk);
		rxActive <= 1;
		settle;
		chk(pllFreeze, 1);
		@(posedge sys_clk);
		rxActive <= 0;
		settle;
		chk({pllFreeze, pllTc}, 8'h01);
		$display("test pll done");
	endtask

	task t_parity;
		wr(6'h1d, 8'h00);
		sendBit(1, 1, 0);
		chk({parityErr, dataValid}, 8'h02);
		sendBit(1, 0, 0);
		chk({dataValid, dataBit}, 8'h03);
		wr(6'h1d, 8'h10);
		settle;
		chk({parityGenEn, parityChkEn}, 8'h00);
		sendBit(1, 1, 0);
		chk({parityErr, dataValid, dataBit}, 8'h03);
		$display("test parity done");
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 0;
		t_regs;
		t_resp;
		t_chan;
		t_level;
		t_pll;
		t_parity;
		test_done;
	end

	// Whole run is well under 1000 cycles
	initial begin
		#100000;
		mismatches++;
		test_done;
	end
endmodule

// ==== hdl/rxdf_config.sv ====
`timescale 1ns/100ps
`include "rxdf_consts.svh"
module rxdf_config #(
	parameter int AMP_W = 8
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register port
	input wire logic [5:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [7:0] rdData,
	// Receiver front end
	input wire logic [AMP_W-1:0] strengthI,
	input wire logic [AMP_W-1:0] strengthQ,
	input wire logic halfValid,
	input wire logic [AMP_W-1:0] halfWeak,
	input wire logic [AMP_W-1:0] halfStrong,
	input wire logic commActive,
	input wire logic rxActive,
	// Receive bit stream
	input wire logic rxBitValid,
	input wire logic rxBit,
	input wire logic rxBitIsParity,
	input wire logic rxParityExp,
	// Decoder and PLL control
	output logic chanQ,
	output logic evalEn,
	output logic collision,
	output logic [1:0] pllTc,
	output logic pllFreeze,
	// Framing control
	output logic [3:0] respBits,
	output logic parityGenEn,
	output logic parityChkEn,
	output logic dataValid,
	output logic dataBit,
	output logic parityErr
);

	rxdf_pkg::rxdf_state_s st_reg;
	rxdf_pkg::rxdf_state_s st_next;

	logic [3:0] min_signal_level;
	logic [2:0] collision_level;
	logic [1:0] comb;
	logic channel_fix;
	logic parOff;
	logic qStronger;
	logic [AMP_W-1:0] selStrength;
	logic selQ;
	logic chanNext;
	logic [AMP_W+2:0] weakScaled;
	logic [AMP_W+2:0] strongScaled;

	// ----------------------------------------
	// Field decode
	// ----------------------------------------
	assign min_signal_level = st_reg.thrReg[`RXDF_MIN_HI:`RXDF_MIN_LO];
	assign collision_level = st_reg.thrReg[`RXDF_COLL_HI:`RXDF_COLL_LO];
	assign comb = st_reg.demReg[`RXDF_COMB_HI:`RXDF_COMB_LO];
	assign channel_fix = st_reg.demReg[`RXDF_FIX];
	assign parOff = st_reg.rxfReg[`RXDF_POFF];
	assign qStronger = strengthQ > strengthI;

	always_comb begin
		st_next = st_reg;
		// Register writes keep reserved bits at reset value
		if (wrStb) begin
			case (addr)
				`RXDF_ADDR_THR: begin
					st_next.thrReg = (wrData & `RXDF_WMASK_THR)
						| (`RXDF_RST_THR & ~`RXDF_WMASK_THR);
				end
				`RXDF_ADDR_DEM: begin
					st_next.demReg = (wrData & `RXDF_WMASK_DEM)
						| (`RXDF_RST_DEM & ~`RXDF_WMASK_DEM);
				end
				`RXDF_ADDR_TXF: begin
					st_next.txfReg = (wrData & `RXDF_WMASK_TXF)
						| (`RXDF_RST_TXF & ~`RXDF_WMASK_TXF);
				end
				`RXDF_ADDR_RXF: begin
					st_next.rxfReg = (wrData & `RXDF_WMASK_RXF)
						| (`RXDF_RST_RXF & ~`RXDF_WMASK_RXF);
				end
				default: begin
				end
			endcase
		end
		// Read data stands one cycle after the strobe; unmapped reads zero
		st_next.rdData = 8'h00;
		if (rdStb) begin
			case (addr)
				`RXDF_ADDR_THR: st_next.rdData = st_reg.thrReg;
				`RXDF_ADDR_DEM: st_next.rdData = st_reg.demReg;
				`RXDF_ADDR_RSV1A: st_next.rdData = `RXDF_RST_RSV;
				`RXDF_ADDR_RSV1B: st_next.rdData = `RXDF_RST_RSV;
				`RXDF_ADDR_TXF: st_next.rdData = st_reg.txfReg;
				`RXDF_ADDR_RXF: st_next.rdData = st_reg.rxfReg;
				`RXDF_ADDR_RSV1E: st_next.rdData = `RXDF_RST_RSV;
				default: st_next.rdData = 8'h00;
			endcase
		end

		// ----------------------------------------
		// Channel choice
		// ----------------------------------------
		st_next.commPrev = commActive;
		st_next.chanQ = chanNext;

		// ----------------------------------------
		// Decoder thresholds
		// ----------------------------------------
		// The minimum level compares with the top four bits of the strength
		st_next.evalEn = selStrength[AMP_W-1 -: 4] >= min_signal_level;
		// Weak half scaled by eight against strong times level
		st_next.collision = st_next.evalEn && halfValid
			&& (weakScaled >= strongScaled);

		// ----------------------------------------
		// PLL control
		// ----------------------------------------
		if (rxActive) begin
			st_next.pllTc = st_reg.demReg[`RXDF_TRCV_HI:`RXDF_TRCV_LO];
		end else begin
			st_next.pllTc = st_reg.demReg[`RXDF_TSYN_HI:`RXDF_TSYN_LO];
		end
		st_next.pllFreeze = rxActive && (st_reg.demReg[`RXDF_TRCV_HI:
			`RXDF_TRCV_LO] == `RXDF_TAU_FREEZE);

		// ----------------------------------------
		// Framing
		// ----------------------------------------
		st_next.respBits = {2'b00, st_reg.txfReg[`RXDF_TXW_HI:`RXDF_TXW_LO]}
			+ `RXDF_RESP_ADD;
		st_next.parityGenEn = !parOff;
		st_next.parityChkEn = !parOff;
		// Parity bits are swallowed unless parity is off
		st_next.dataValid = rxBitValid && (!rxBitIsParity || parOff);
		st_next.dataBit = rxBit;
		st_next.parityErr = rxBitValid && rxBitIsParity && !parOff
			&& (rxBit != rxParityExp);
	end

	// Channel choice kept apart from the state copy so that the level
	// compare above does not loop back through the same process
	always_comb begin
		chanNext = st_reg.chanQ;
		if (channel_fix) begin
			chanNext = comb[0];
		end else if (comb == `RXDF_COMB_HOLD) begin
			// Chosen at the start of a communication, then held
			if (!(commActive && st_reg.commPrev)) begin
				chanNext = qStronger;
			end
		end else begin
			// Reserved codes behave as the stronger-channel choice
			chanNext = qStronger;
		end
	end

	// Held channel only moves outside a communication or on its first cycle, so a weak
	// fade mid-frame cannot flip the decoder input
	assign selQ = chanNext;
	assign selStrength = selQ ? strengthQ : strengthI;
	assign weakScaled = {halfWeak, 3'b000};
	assign strongScaled = (AMP_W+3)'({3'b000, halfStrong} * collision_level);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.thrReg <= `RXDF_RST_THR;
			st_reg.demReg <= `RXDF_RST_DEM;
			st_reg.txfReg <= `RXDF_RST_TXF;
			st_reg.rxfReg <= `RXDF_RST_RXF;
			st_reg.respBits <= `RXDF_RESP_ADD;
			st_reg.parityGenEn <= 1'b1;
			st_reg.parityChkEn <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdData = st_reg.rdData;
	assign chanQ = st_reg.chanQ;
	assign evalEn = st_reg.evalEn;
	assign collision = st_reg.collision;
	assign pllTc = st_reg.pllTc;
	assign pllFreeze = st_reg.pllFreeze;
	assign respBits = st_reg.respBits;
	assign parityGenEn = st_reg.parityGenEn;
	assign parityChkEn = st_reg.parityChkEn;
	assign dataValid = st_reg.dataValid;
	assign dataBit = st_reg.dataBit;
	assign parityErr = st_reg.parityErr;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_rsvRead;
		@(posedge sys_clk) disable iff (rst)
		rdStb && (addr == `RXDF_ADDR_RSV1A || addr == `RXDF_ADDR_RSV1B
			|| addr == `RXDF_ADDR_RSV1E) |=> rdData == `RXDF_RST_RSV;
	endproperty
	a_rsvRead: assert property (p_rsvRead)
		else $error("Reserved register read nonzero");

	property p_thrBit3;
		@(posedge sys_clk) disable iff (rst)
		wrStb && addr == `RXDF_ADDR_THR ##1 rdStb && addr == `RXDF_ADDR_THR
			|=> rdData == ((wrData & 8'h00) | ($past(wrData, 2)
			& `RXDF_WMASK_THR) | (`RXDF_RST_THR & ~`RXDF_WMASK_THR));
	endproperty
	a_thrBit3: assert property (p_thrBit3)
		else $error("Threshold write readback wrong");

	property p_fixChan;
		@(posedge sys_clk) disable iff (rst)
		channel_fix ##1 channel_fix |-> chanQ == $past(comb[0]);
	endproperty
	a_fixChan: assert property (p_fixChan)
		else $error("Fixed channel not honoured");

	property p_holdChan;
		@(posedge sys_clk) disable iff (rst)
		!channel_fix && comb == `RXDF_COMB_HOLD && commActive
			&& $past(commActive) ##1 !channel_fix && comb == `RXDF_COMB_HOLD
			|-> $stable(chanQ);
	endproperty
	a_holdChan: assert property (p_holdChan)
		else $error("Held channel changed in communication");

	property p_freeze;
		@(posedge sys_clk) disable iff (rst)
		rxActive
			&& st_reg.demReg[`RXDF_TRCV_HI:`RXDF_TRCV_LO] == `RXDF_TAU_FREEZE
			|=> pllFreeze && pllTc == `RXDF_TAU_FREEZE;
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("PLL not frozen in reception");

	property p_burstTc;
		@(posedge sys_clk) disable iff (rst)
		!rxActive |=> !pllFreeze
			&& pllTc == $past(st_reg.demReg[`RXDF_TSYN_HI:`RXDF_TSYN_LO]);
	endproperty
	a_burstTc: assert property (p_burstTc)
		else $error("Burst time constant wrong");

	property p_resp;
		@(posedge sys_clk) disable iff (rst)
		1'b1 |=> respBits == 4'($past(st_reg.txfReg[`RXDF_TXW_HI:
			`RXDF_TXW_LO]) + `RXDF_RESP_ADD);
	endproperty
	a_resp: assert property (p_resp)
		else $error("Response time not field plus seven");

	property p_parPass;
		@(posedge sys_clk) disable iff (rst)
		rxBitValid && rxBitIsParity && parOff
			|=> dataValid && !parityErr && dataBit == $past(rxBit);
	endproperty
	a_parPass: assert property (p_parPass)
		else $error("Parity bit not passed as data");

	property p_parChk;
		@(posedge sys_clk) disable iff (rst)
		rxBitValid && rxBitIsParity && !parOff && rxBit != rxParityExp
			|=> parityErr && !dataValid && parityGenEn;
	endproperty
	a_parChk: assert property (p_parChk)
		else $error("Parity error missed");

	property p_weak;
		@(posedge sys_clk) disable iff (rst)
		selStrength[AMP_W-1 -: 4] < min_signal_level |=> !evalEn && !collision;
	endproperty
	a_weak: assert property (p_weak)
		else $error("Weak signal evaluated");

	property p_strong;
		@(posedge sys_clk) disable iff (rst)
		selStrength[AMP_W-1 -: 4] >= min_signal_level |=> evalEn;
	endproperty
	a_strong: assert property (p_strong)
		else $error("Strong signal not evaluated");

	property p_rdIdle;
		@(posedge sys_clk) disable iff (rst)
		!rdStb |=> rdData == `RXDF_RST_RSV;
	endproperty
	a_rdIdle: assert property (p_rdIdle)
		else $error("Read data outside read cycle");

	property p_parOffCtl;
		@(posedge sys_clk) disable iff (rst)
		parOff |=> !parityGenEn && !parityChkEn && !parityErr;
	endproperty
	a_parOffCtl: assert property (p_parOffCtl)
		else $error("Parity still active while off");

	property p_combStrong;
		@(posedge sys_clk) disable iff (rst)
		!channel_fix && comb == `RXDF_COMB_STRONG |=> chanQ == $past(qStronger);
	endproperty
	a_combStrong: assert property (p_combStrong)
		else $error("Stronger channel not chosen");

endmodule

// ==== pkg/rxdf_consts.svh ====
`ifndef RXDF_CONSTS_SVH
`define RXDF_CONSTS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define RXDF_ADDR_THR 6'h18
`define RXDF_ADDR_DEM 6'h19
`define RXDF_ADDR_RSV1A 6'h1a
`define RXDF_ADDR_RSV1B 6'h1b
`define RXDF_ADDR_TXF 6'h1c
`define RXDF_ADDR_RXF 6'h1d
`define RXDF_ADDR_RSV1E 6'h1e
`define RXDF_RST_THR 8'h84
`define RXDF_RST_DEM 8'h4d
`define RXDF_RST_TXF 8'h62
`define RXDF_RST_RXF 8'h00
`define RXDF_RST_RSV 8'h00
`define RXDF_WMASK_THR 8'hf7
`define RXDF_WMASK_DEM 8'hef
`define RXDF_WMASK_TXF 8'h03
`define RXDF_WMASK_RXF 8'h10
// ----------------------------------------
// Fields
// ----------------------------------------
`define RXDF_MIN_HI 7
`define RXDF_MIN_LO 4
`define RXDF_COLL_HI 2
`define RXDF_COLL_LO 0
`define RXDF_COMB_HI 7
`define RXDF_COMB_LO 6
`define RXDF_FIX 5
`define RXDF_TRCV_HI 3
`define RXDF_TRCV_LO 2
`define RXDF_TSYN_HI 1
`define RXDF_TSYN_LO 0
`define RXDF_TXW_HI 1
`define RXDF_TXW_LO 0
`define RXDF_POFF 4
`define RXDF_COMB_STRONG 2'b00
`define RXDF_COMB_HOLD 2'b01
`define RXDF_TAU_FREEZE 2'b00
`define RXDF_RESP_ADD 4'h7
`define RXDF_COLL_SHIFT 3
`endif

// ==== pkg/rxdf_pkg.sv ====
package rxdf_pkg;
	typedef struct packed {
		logic [7:0] thrReg;
		logic [7:0] demReg;
		logic [7:0] txfReg;
		logic [7:0] rxfReg;
		logic [7:0] rdData;
		logic chanQ;
		logic commPrev;
		logic evalEn;
		logic collision;
		logic [1:0] pllTc;
		logic pllFreeze;
		logic [3:0] respBits;
		logic parityGenEn;
		logic parityChkEn;
		logic dataValid;
		logic dataBit;
		logic parityErr;
	} rxdf_state_s;
endpackage
